// *** src/vid_params.svh ***
`ifndef VID_PARAMS_SVH
`define VID_PARAMS_SVH

// =====================================================================
// Register map of the plain register port.
`define VID_ADDR_W         4
`define VID_OFF_STATUS     4'h0
`define VID_OFF_CAUSE      4'h1
`define VID_OFF_VECCTL     4'h2
`define VID_OFF_CONFIG     4'h3
`define VID_OFF_SRSMAP     4'h4
`define VID_OFF_SHADOW     4'h5
`define VID_OFF_DISPATCH   4'h6

// =====================================================================
// Field positions.
`define VID_ST_GIE         0
`define VID_ST_EXC         1
`define VID_ST_ERR         2
`define VID_ST_BOOT        3
`define VID_ST_MASK_LO     8
`define VID_CA_SPV         23
`define VID_CA_TI          30
`define VID_CA_DC          26
`define VID_CFG_VCAP       0
`define VID_CFG_XCP        1

// =====================================================================
// Reset values and constants.
`define VID_SPACING_RESET  5'h00
`define VID_BASE_OFFSET    17'h00200
`define VID_COMPAT_OFFSET  17'h00200
`define VID_NUM_REQ        10

`endif

// *** src/vid_pkg.sv ***
package vid_pkg;
  typedef enum logic [1:0] {
    VID_MODE_COMPAT,
    VID_MODE_VECTORED,
    VID_MODE_EXT
  } vid_mode_t;
endpackage

// *** src/vid_prio_enc.sv ***
`include "vid_params.svh"

// =====================================================================
// Ten-input priority encoder, bit nine highest.
module vid_prio_enc (
  input  wire logic [9:0] req_i,
  output logic            any_o,
  output logic [3:0]      vec_o
);
  import vid_pkg::*;

  // Scan upward so the last hit, the highest index, wins.
  always_comb begin
    any_o = 1'b0;
    vec_o = 4'h0;
    for (int i = 0; i < `VID_NUM_REQ; i++) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        vec_o = 4'(i);
      end
    end
  end
endmodule

// *** src/vid_dispatch.sv ***
`include "vid_params.svh"

// =====================================================================
// Interrupt dispatch: picks the interrupt mode, ranks or forwards the
// requests, and hands the pipeline a request, an entry offset and a set.

// What this block does
// - Vectored mode needs capability, no ext controller, nonzero spacing, special vector, no boot vector.
// - Vectored mode treats the eight hardware inputs as independent request lines.
// - Pending AND mask; interrupt only with enable set and exception, error levels clear.
// - Encoder ranks bit nine (hardware seven) highest down to software zero.
// - Winning vector number feeds the handler entry offset.
// - Each vectored interrupt maps to a shadow register set; vectors eight and nine reuse those of zero and one.
// - Ext mode needs controller present, nonzero spacing, special vector set, boot vector clear.
// - Ext mode exports software, timer and debug-channel requests outward.
// - Ext mode interrupts only when requested level exceeds current level and enabled.
// - On taking the interrupt capture level, load shadow set, acknowledge controller.
// - Offset is vector times spacing shifted left five, plus 16#200.
module vid_dispatch (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic [`VID_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [31:0]                 rdata_o,
  input  wire logic [7:0]             hw_int_i,
  input  wire logic                   timer_req_i,
  input  wire logic                   debug_chan_req_i,
  input  wire logic                   ext_controller_present_i,
  input  wire logic [2:0]             timer_line_select_i,
  input  wire logic [5:0]             ext_vector_i,
  input  wire logic [3:0]             ext_shadow_set_i,
  input  wire logic                   exc_start_i,
  output logic                        int_req_o,
  output vid_pkg::vid_mode_t          mode_o,
  output logic [16:0]                 vector_offset_o,
  output logic [3:0]                  shadow_set_o,
  output logic [1:0]                  sw_req_o,
  output logic                        timer_req_o,
  output logic                        debug_chan_req_o,
  output logic                        ext_ack_o
);
  import vid_pkg::*;

  // =====================================================================
  // Reset synchroniser.
  logic rst_s1_q;
  logic rst_n_q;

  // Release is delayed two edges so every flop leaves reset together.
  // Entry stays asynchronous so the outputs clear even while the clock is stopped.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // =====================================================================
  // Software-visible control state.
  logic        gie_q;
  logic        exc_lvl_q;
  logic        err_lvl_q;
  logic        boot_vec_q;
  logic [7:0]  hw_mask_q;
  logic [1:0]  sw_mask_q;
  logic [1:0]  sw_pend_q;
  logic        spec_vec_q;
  logic [4:0]  spacing_q;
  logic [39:0] srs_map_q;
  // Captured only when an ext-mode interrupt exception starts.
  logic [7:0]  cause_level_q;
  logic [3:0]  ext_ss_q;
  logic        vec_cap;

  // Vectored mode is always built in, so the capability bit is a fixed one.
  assign vec_cap = 1'b1;

  // Status fields; the mask field doubles as the current level in ext mode.
  // Software owns both meanings, so a level written in vectored mode acts as a mask.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gie_q      <= 1'b0;
      exc_lvl_q  <= 1'b0;
      err_lvl_q  <= 1'b1;
      boot_vec_q <= 1'b1;
      hw_mask_q  <= 8'h00;
      sw_mask_q  <= 2'h0;
    end else if (wr_i && addr_i == `VID_OFF_STATUS) begin
      gie_q      <= wdata_i[`VID_ST_GIE];
      exc_lvl_q  <= wdata_i[`VID_ST_EXC];
      err_lvl_q  <= wdata_i[`VID_ST_ERR];
      boot_vec_q <= wdata_i[`VID_ST_BOOT];
      sw_mask_q  <= wdata_i[`VID_ST_MASK_LO +: 2];
      hw_mask_q  <= wdata_i[`VID_ST_MASK_LO+2 +: 8];
    end
  end

  // Software request bits and the special vector select.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sw_pend_q  <= 2'h0;
      spec_vec_q <= 1'b0;
    end else if (wr_i && addr_i == `VID_OFF_CAUSE) begin
      sw_pend_q  <= wdata_i[`VID_ST_MASK_LO +: 2];
      spec_vec_q <= wdata_i[`VID_CA_SPV];
    end
  end

  // Vector spacing; zero after reset keeps the core in compatibility mode.
  // Only five bits are kept, so no spacing above 992 bytes can be set.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      spacing_q <= `VID_SPACING_RESET;
    end else if (wr_i && addr_i == `VID_OFF_VECCTL) begin
      spacing_q <= wdata_i[9:5];
    end
  end

  // Shadow-set map, four bits per vector, vector zero in the low nibble.
  // The top byte repeats the low byte, so vectors eight and nine share sets with zero and one.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      srs_map_q <= 40'h0;
    end else if (wr_i && addr_i == `VID_OFF_SRSMAP) begin
      srs_map_q <= {wdata_i[7:0], wdata_i};
    end
  end

  // =====================================================================
  // Mode selection.
  vid_mode_t mode;

  // Ext mode wins when the strap is set and the shared conditions hold; vectored mode also needs the capability.
  always_comb begin
    mode = VID_MODE_COMPAT;
    if (!boot_vec_q && spec_vec_q && spacing_q != 5'h00) begin
      if (ext_controller_present_i) begin
        mode = VID_MODE_EXT;
      end else if (vec_cap) begin
        mode = VID_MODE_VECTORED;
      end
    end
  end

  // =====================================================================
  // Vectored request path.
  logic [9:0] pending;
  logic [9:0] masked;
  logic       any_req;
  logic [3:0] enc_vec;
  logic       int_enabled;

  // Each hardware input is its own line; the timer is merged outside the core.
  // Software bits sit below the hardware lines, so they always rank lowest.
  assign pending     = {hw_int_i, sw_pend_q};
  assign int_enabled = gie_q && !exc_lvl_q && !err_lvl_q;

  // One AND gate per request bit.
  genvar g;
  generate
    for (g = 0; g < `VID_NUM_REQ; g++) begin : g_mask
      if (g < 2) begin : g_sw
        assign masked[g] = pending[g] & sw_mask_q[g];
      end else begin : g_hw
        assign masked[g] = pending[g] & hw_mask_q[g-2];
      end
    end
  endgenerate

  // The encoder only ranks; the mode decides whether its vector is used.
  vid_prio_enc u_enc (
    .req_i (masked),
    .any_o (any_req),
    .vec_o (enc_vec)
  );

  // =====================================================================
  // Request decision, vector and shadow set per mode.
  logic        req_d;
  logic [5:0]  vec_num;
  logic [3:0]  ss_d;
  logic [16:0] off_d;

  // The vector is formed every cycle and the pipeline chooses when to take it,
  // so a request that drops before the start leaves no trace behind.
  always_comb begin
    req_d   = 1'b0;
    vec_num = 6'h00;
    ss_d    = 4'h0;
    case (mode)
      VID_MODE_VECTORED: begin
        req_d   = any_req && int_enabled;
        vec_num = {2'b00, enc_vec};
        ss_d    = srs_map_q[enc_vec*4 +: 4];
      end
      VID_MODE_EXT: begin
        // Level zero never passes because the compare is strict.
        req_d   = (hw_int_i > hw_mask_q) && int_enabled;
        vec_num = ext_vector_i;
        ss_d    = ext_shadow_set_i;
      end
      default: begin
        req_d   = (|(pending & {hw_mask_q, sw_mask_q})) && int_enabled;
      end
    endcase
  end

  // Offset is formed from the chosen vector; compat uses the fixed offset.
  always_comb begin
    if (mode == VID_MODE_COMPAT) begin
      off_d = `VID_COMPAT_OFFSET;
    end else begin
      // Both factors are widened first: a ten-bit product would lose the upper
      // offsets, while 63 times 992 plus 16#200 still fits in seventeen bits.
      off_d = 17'(vec_num) * 17'({spacing_q, 5'b00000}) + `VID_BASE_OFFSET;
    end
  end

  // =====================================================================
  // Registered outputs to pipeline and controller.
  // Each output costs one cycle of latency but never glitches at the pins.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_req_o       <= 1'b0;
      mode_o          <= VID_MODE_COMPAT;
      vector_offset_o <= 17'h0;
      shadow_set_o    <= 4'h0;
    end else begin
      int_req_o       <= req_d;
      mode_o          <= mode;
      vector_offset_o <= off_d;
      shadow_set_o    <= ss_d;
    end
  end

  // Exported requests are held low outside ext mode so the controller sees no noise.
  // The gating adds no delay, since the mode is formed in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sw_req_o         <= 2'h0;
      timer_req_o      <= 1'b0;
      debug_chan_req_o <= 1'b0;
    end else begin
      sw_req_o         <= (mode == VID_MODE_EXT) ? sw_pend_q : 2'h0;
      timer_req_o      <= (mode == VID_MODE_EXT) && timer_req_i;
      debug_chan_req_o <= (mode == VID_MODE_EXT) && debug_chan_req_i;
    end
  end

  // Capture level and shadow set as the exception starts, pulse the acknowledge.
  // Only the registered request qualifies a start, so a start that meets a
  // request already gone is ignored and never acknowledged.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cause_level_q <= 8'h00;
      ext_ss_q      <= 4'h0;
      ext_ack_o     <= 1'b0;
    end else begin
      ext_ack_o <= 1'b0;
      if (exc_start_i && int_req_o && mode_o == VID_MODE_EXT) begin
        cause_level_q <= hw_int_i;
        ext_ss_q      <= ext_shadow_set_i;
        ext_ack_o     <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Read port; data stand one cycle after the strobe, unmapped reads zero.
  // Live inputs are read as sampled at the strobe; nothing holds them longer.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        `VID_OFF_STATUS:   rdata_o <= {14'h0, hw_mask_q, sw_mask_q, 4'h0,
                                       boot_vec_q, err_lvl_q, exc_lvl_q, gie_q};
        `VID_OFF_CAUSE:    rdata_o <= {1'b0, timer_req_i, 3'h0, debug_chan_req_i, 2'h0,
                                       spec_vec_q, 5'h0, (mode == VID_MODE_EXT) ? cause_level_q
                                       : hw_int_i, sw_pend_q, 8'h00};
        `VID_OFF_VECCTL:   rdata_o <= {timer_line_select_i, 19'h0, spacing_q, 5'h0};
        `VID_OFF_CONFIG:   rdata_o <= {30'h0, ext_controller_present_i, vec_cap};
        `VID_OFF_SRSMAP:   rdata_o <= srs_map_q[31:0];
        `VID_OFF_SHADOW:   rdata_o <= {14'h0, ext_ss_q, 14'h0};
        `VID_OFF_DISPATCH: rdata_o <= {3'h0, enc_vec, any_req, 5'h0, mode, off_d};
        default:           rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end
endmodule

// *** tb/vid_dispatch_properties.sv ***
// =====================================================================
// Port-level checks for the dispatch block.
module vid_dispatch_properties (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic [7:0]         hw_int_i,
  input wire logic               timer_req_i,
  input wire logic               debug_chan_req_i,
  input wire logic               exc_start_i,
  input wire logic               int_req_o,
  input wire vid_pkg::vid_mode_t mode_o,
  input wire logic [16:0]        vector_offset_o,
  input wire logic [1:0]         sw_req_o,
  input wire logic               timer_req_o,
  input wire logic               debug_chan_req_o,
  input wire logic               ext_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import vid_pkg::*;

  // One clock domain, so clock and reset are given once for all.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_ack_after_start: assert property (
    exc_start_i && int_req_o && mode_o == VID_MODE_EXT |=> ext_ack_o)
    else $error("no acknowledge after exception start");
  a_ack_has_cause: assert property (
    ext_ack_o |-> $past(exc_start_i) && $past(int_req_o))
    else $error("acknowledge without a taken request");
  a_export_off: assert property (
    mode_o != VID_MODE_EXT [*2] |-> sw_req_o == 2'h0 && !timer_req_o && !debug_chan_req_o)
    else $error("requests exported outside external mode");
  a_timer_export: assert property (
    mode_o == VID_MODE_EXT [*2] |-> timer_req_o == $past(timer_req_i))
    else $error("timer request not exported");
  a_debug_export: assert property (
    mode_o == VID_MODE_EXT [*2] |-> debug_chan_req_o == $past(debug_chan_req_i))
    else $error("debug request not exported");
  a_zero_level: assert property (
    mode_o == VID_MODE_EXT [*2] ##0 $past(hw_int_i) == 8'h00 |-> !int_req_o)
    else $error("request raised with level zero");
  a_compat_offset: assert property (
    mode_o == VID_MODE_COMPAT && vector_offset_o != 17'h0 |-> vector_offset_o == 17'h200)
    else $error("compatibility offset wrong");
  a_offset_form: assert property (
    mode_o != VID_MODE_COMPAT |-> vector_offset_o[4:0] == 5'h0 && vector_offset_o >= 17'h200)
    else $error("vector offset malformed");

  c_ack: cover property (ext_ack_o);
  c_vec_req: cover property (mode_o == VID_MODE_VECTORED && int_req_o);
  c_ext_req: cover property (mode_o == VID_MODE_EXT && int_req_o);
endmodule

// *** tb/vid_int_source.sv ***
// =====================================================================
// Interrupt sources and outside controller facing the core.
module vid_int_source (
  input  wire logic       ext_mode_i,
  input  wire logic [7:0] src_i,
  input  wire logic       timer_i,
  input  wire logic [2:0] line_sel_i,
  input  wire logic [7:0] lvl_i,
  input  wire logic [5:0] vec_i,
  input  wire logic [3:0] ss_i,
  input  wire logic [3:0] exp_i,
  output logic      [7:0] hw_o,
  output logic      [5:0] vec_o,
  output logic      [3:0] ss_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle vector lines show the inverse of the last value, never a stale copy.
  always_comb begin
    vec_o = ~vec_i;
    ss_o  = ~ss_i;
    if (!ext_mode_i) begin
      hw_o = src_i | (8'(timer_i) << line_sel_i);
    end else if (lvl_i != 8'h00) begin
      hw_o  = lvl_i;
      vec_o = vec_i;
      ss_o  = ss_i;
    end else if (|exp_i) begin
      hw_o  = 8'h01;
      vec_o = 6'h01;
      ss_o  = 4'h0;
    end else begin
      hw_o = 8'h00;
    end
  end
endmodule

// *** tb/vectored_interrupt_dispatch_test.sv ***
`include "vid_params.svh"

module vectored_interrupt_dispatch_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vid_pkg::*;

  // =====================================================================
  // Stimulus and observed signals.
  localparam logic [2:0]  TSEL = 3'h5;
  localparam logic [39:0] SMAP = 40'hef89abcdef;
  logic        clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic        exc_i = 1'b0, timer = 1'b0, dbg = 1'b0, eicp = 1'b0;
  logic [3:0]  addr_i = 4'h0, ss = 4'h0, ess, sso;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [31:0] inh [4] = '{32'h3ff03, 32'h3ff05, 32'h3ff00, 32'h00001};
  logic [7:0]  src = 8'h00, lvl = 8'h00, hw;
  logic [5:0]  vec = 6'h00, evec;
  logic [16:0] off;
  logic [1:0]  swo;
  logic        irq, tmo, dco, ack;
  vid_mode_t   mode;
  int          n_errors = 0, checks = 0;

  vid_int_source u_src (
    .ext_mode_i(eicp), .src_i(src), .timer_i(timer), .line_sel_i(TSEL), .lvl_i(lvl),
    .vec_i(vec), .ss_i(ss), .exp_i({swo, tmo, dco}), .hw_o(hw), .vec_o(evec), .ss_o(ess));
  vid_dispatch DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .hw_int_i(hw), .timer_req_i(timer),
    .debug_chan_req_i(dbg), .ext_controller_present_i(eicp), .timer_line_select_i(TSEL),
    .ext_vector_i(evec), .ext_shadow_set_i(ess), .exc_start_i(exc_i), .int_req_o(irq),
    .mode_o(mode), .vector_offset_o(off), .shadow_set_o(sso), .sw_req_o(swo),
    .timer_req_o(tmo), .debug_chan_req_o(dco), .ext_ack_o(ack));

  // Clock of 25 ns.
  always #12.5 clk_i = ~clk_i;

  // =====================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o & m, e);
  endtask
  // Outputs lag inputs by up to two edges; one spare edge keeps sampling clear.
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic mcase(input logic [31:0] st, ca, ic, input logic e, input vid_mode_t m);
    @(posedge clk_i);
    eicp <= e;
    wr(`VID_OFF_VECCTL, ic);
    wr(`VID_OFF_CAUSE, ca);
    wr(`VID_OFF_STATUS, st);
    settle();
    chk(32'(mode), 32'(m));
    if (m == VID_MODE_VECTORED) chk(32'(off), 32'h320);
    if (m == VID_MODE_COMPAT) chk(32'(off), 32'h200);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // =====================================================================
  // Test sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(`VID_OFF_STATUS, 32'hc, 32'hf);
    rd(`VID_OFF_CONFIG, 32'h1, 32'h3);
    rd(4'h7, 32'h0, 32'hffffffff);
    rd(`VID_OFF_VECCTL, 32'ha0000000, 32'he00003e0);
    chk(32'(mode), 32'(VID_MODE_COMPAT));
    wr(`VID_OFF_SRSMAP, SMAP[31:0]);
    src <= 8'h80;
    mcase(32'h3ff09, 32'h800000, 32'h20, 1'b0, VID_MODE_COMPAT);
    mcase(32'h3ff01, 32'h000000, 32'h20, 1'b0, VID_MODE_COMPAT);
    mcase(32'h3ff01, 32'h800000, 32'h00, 1'b0, VID_MODE_COMPAT);
    mcase(32'h3ff09, 32'h800000, 32'h20, 1'b1, VID_MODE_COMPAT);
    mcase(32'h3ff01, 32'h800000, 32'h20, 1'b1, VID_MODE_EXT);
    mcase(32'h3ff01, 32'h800000, 32'h20, 1'b0, VID_MODE_VECTORED);
    // Lower lines stay raised so a wrongly encoded input would pick another vector.
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      src <= 8'hff >> (7 - k);
      settle();
      chk(32'(irq), 32'h1);
      chk(32'(off), 32'h200 + (k + 2) * 32'h20);
      chk(32'(sso), 32'(SMAP[4*(k+2) +: 4]));
    end
    @(posedge clk_i);
    src <= 8'h00;
    wr(`VID_OFF_CAUSE, 32'h800300);
    settle();
    chk(32'(off), 32'h220);
    wr(`VID_OFF_CAUSE, 32'h800100);
    settle();
    chk(32'(off), 32'h200);
    @(posedge clk_i);
    src <= 8'h81;
    wr(`VID_OFF_STATUS, 32'h1ff01);
    settle();
    chk(32'(off), 32'h240);
    for (int i = 0; i < 4; i++) begin
      wr(`VID_OFF_STATUS, inh[i]);
      settle();
      chk(32'(irq), 32'h0);
    end
    wr(`VID_OFF_STATUS, 32'h3ff01);
    wr(`VID_OFF_VECCTL, 32'h200);
    settle();
    chk(32'(off), 32'h1400);
    @(posedge clk_i);
    src   <= 8'h00;
    timer <= 1'b1;
    wr(`VID_OFF_CAUSE, 32'h800000);
    wr(`VID_OFF_VECCTL, 32'h20);
    settle();
    chk(32'(off), 32'h2e0);
    chk(32'(tmo), 32'h0);
    @(posedge clk_i);
    timer <= 1'b0;
    lvl   <= 8'h03;
    vec   <= 6'h3f;
    ss    <= 4'h9;
    mcase(32'hc01, 32'h800000, 32'h20, 1'b1, VID_MODE_EXT);
    chk(32'(irq), 32'h0);
    @(posedge clk_i);
    lvl <= 8'h04;
    settle();
    chk(32'(irq), 32'h1);
    chk(32'(off), 32'h9e0);
    @(posedge clk_i);
    exc_i <= 1'b1;
    @(posedge clk_i);
    exc_i <= 1'b0;
    @(negedge clk_i);
    chk(32'(ack), 32'h1);
    rd(`VID_OFF_CAUSE, 32'h1000, 32'h3fc00);
    rd(`VID_OFF_SHADOW, 32'h24000, 32'h3c000);
    @(posedge clk_i);
    lvl   <= 8'h00;
    timer <= 1'b1;
    dbg   <= 1'b1;
    wr(`VID_OFF_CAUSE, 32'h800200);
    settle();
    chk({28'h0, swo, tmo, dco}, 32'hb);
    chk(32'(irq), 32'h0);
    conclude();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
endmodule

bind vid_dispatch vid_dispatch_properties u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .hw_int_i(hw_int_i), .timer_req_i(timer_req_i),
  .debug_chan_req_i(debug_chan_req_i), .exc_start_i(exc_start_i), .int_req_o(int_req_o),
  .mode_o(mode_o), .vector_offset_o(vector_offset_o), .sw_req_o(sw_req_o),
  .timer_req_o(timer_req_o), .debug_chan_req_o(debug_chan_req_o), .ext_ack_o(ext_ack_o));
